// [verilog/lrie_stack.sv]
// package of shared constants and the return-address stack memory
package lrie_pkg;
	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic GIE_RESET = 1'b0;
	localparam int GIE_BIT = 7;
	// ---------------------------------------------------------------
	// opcode fields
	// ---------------------------------------------------------------
	localparam int LIT_LSB = 0;
	localparam int OPC_LSB = 10;
	localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
	localparam logic [3:0] OPC_RET_LIT = 4'hD;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_RET_IRQ = 14'h0009;
	localparam logic [13:0] NOP_MASK = 14'h3F9F;
	localparam logic [13:0] NOP_VALUE = 14'h0000;
	// ---------------------------------------------------------------
	// cycle counts
	// ---------------------------------------------------------------
	localparam int CYC_SINGLE = 1;
	localparam int CYC_RETURN = 2;
	typedef enum logic [0:0] {LRIE_EXEC, LRIE_FLUSH} lrie_state_t;
endpackage

`timescale 1ns/1ps
module lrie_stack #(
	parameter int DEPTH = lrie_pkg::STACK_DEPTH,
	parameter int WIDTH = lrie_pkg::PC_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstSync_n,
	input wire logic ce,
	// stack operations
	input wire logic push,
	input wire logic [WIDTH-1:0] pushData,
	input wire logic pop,
	output logic [WIDTH-1:0] topOfStack
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] ptr_reg;
	logic [PW-1:0] below;
	// overflow wraps silently, as a circular stack does
	assign below = ptr_reg - PW'(2);

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[ptr_reg] <= pushData;
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ptr_reg <= '0;
		end else if (ce && push) begin
			ptr_reg <= ptr_reg + PW'(1);
		end else if (ce && pop) begin
			ptr_reg <= ptr_reg - PW'(1);
		end
	end

	// top is kept in a register so the return path sees no memory read delay
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			topOfStack <= '0;
		end else if (ce && push) begin
			topOfStack <= pushData;
		end else if (ce && pop) begin
			topOfStack <= mem[below];
		end
	end
endmodule // lrie_stack

// [verilog/lrie_exec.sv]
// execution of load-literal, no-operation and the three return instructions
`timescale 1ns/1ps
// Behaviour
// RQ1 - Load-literal puts its 8-bit immediate in the working register in one cycle, flags untouched.
// RQ2 - No-operation only advances the program counter, taking one word and one cycle.
// RQ3 - Return-from-irq pops the stack into the program counter in two cycles, flags untouched.
// RQ4 - Return-from-irq also sets the global interrupt enable bit, bit 7 of the irq control register.
// RQ5 - Return-with-literal loads its 8-bit immediate into the working register, flags untouched.
// RQ6 - Return-with-literal loads the program counter from the stack top and takes two cycles.
// RQ7 - Return-from-subroutine pops the stack into the program counter in two cycles.
module lrie_exec (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// instruction word at pcOut
	input wire logic [13:0] instrWord,
	input wire logic instrValid,
	// call and interrupt entry from the rest of the core
	input wire logic pushReq,
	input wire logic [12:0] pushAddr,
	input wire logic irqEntry,
	// core state
	output logic [7:0] workReg,
	output logic [12:0] pcOut,
	output logic [7:0] irqControlReg,
	output logic instrDone,
	output logic busy
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	// asynchronous assert, synchronous release, so no flop leaves reset on a later edge
	logic rstMeta_n;
	logic rstSync_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	lrie_pkg::lrie_state_t state_reg;
	logic [7:0] literal;
	logic isLoadLit;
	logic isRetLit;
	logic isReturn;
	logic isRetIrq;
	logic isNop;
	logic isRet;
	logic exec;
	logic [12:0] topOfStack;
	logic global_irq_enable_bit;

	assign literal = instrWord[lrie_pkg::LIT_LSB +: lrie_pkg::DATA_W];
	assign isLoadLit = instrWord[13:lrie_pkg::OPC_LSB] == lrie_pkg::OPC_LOAD_LIT;
	assign isRetLit = instrWord[13:lrie_pkg::OPC_LSB] == lrie_pkg::OPC_RET_LIT;
	assign isReturn = instrWord == lrie_pkg::OP_RETURN;
	assign isRetIrq = instrWord == lrie_pkg::OP_RET_IRQ;
	// bits 6:5 of a no-operation assemble as zero, but any value there is tolerated
	assign isNop = (instrWord & lrie_pkg::NOP_MASK) == lrie_pkg::NOP_VALUE;
	assign isRet = isRetLit || isReturn || isRetIrq;
	// the flush cycle ignores the bus, so a word offered then is not executed
	assign exec = ce && instrValid && (state_reg == lrie_pkg::LRIE_EXEC);
	assign busy = state_reg == lrie_pkg::LRIE_FLUSH;

	// ---------------------------------------------------------------
	// return stack
	// ---------------------------------------------------------------
	lrie_stack #(
		.DEPTH(lrie_pkg::STACK_DEPTH),
		.WIDTH(lrie_pkg::PC_W)
	) u_stack (
		.clk(clk),
		.rstSync_n(rstSync_n),
		.ce(ce),
		// a push in the cycle of a return is dropped: the return owns the stack then
		.push(pushReq && !(exec && isRet)),
		.pushData(pushAddr),
		.pop(exec && isRet), // RQ3 RQ6 RQ7
		.topOfStack(topOfStack)
	);

	// ---------------------------------------------------------------
	// sequencing: returns spend a second, idle cycle
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg <= lrie_pkg::LRIE_EXEC;
		end else if (ce) begin
			case (state_reg)
				lrie_pkg::LRIE_EXEC: begin
					if (exec && isRet) begin
						state_reg <= lrie_pkg::LRIE_FLUSH; // RQ3 RQ6 RQ7
					end
				end
				lrie_pkg::LRIE_FLUSH: begin
					state_reg <= lrie_pkg::LRIE_EXEC;
				end
				default: begin
					state_reg <= lrie_pkg::LRIE_EXEC;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			instrDone <= 1'b0;
		end else if (ce) begin
			// single-cycle words pulse with their result, returns after the idle cycle
			instrDone <= (exec && !isRet) || busy;
		end
	end

	// ---------------------------------------------------------------
	// program counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pcOut <= lrie_pkg::PC_RESET;
		end else if (exec && isRet) begin
			pcOut <= topOfStack; // RQ3 RQ6 RQ7
		end else if (exec) begin
			// unlisted opcodes land here as well and only advance the counter
			pcOut <= pcOut + 13'h0001; // RQ2
		end
	end

	// ---------------------------------------------------------------
	// working register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			workReg <= lrie_pkg::WORK_RESET;
		end else if (exec && (isLoadLit || isRetLit)) begin
			workReg <= literal; // RQ1 RQ5
		end
	end

	// ---------------------------------------------------------------
	// global interrupt enable
	// ---------------------------------------------------------------
	// the return wins over a simultaneous interrupt entry so the enable is not lost
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			global_irq_enable_bit <= lrie_pkg::GIE_RESET;
		end else if (exec && isRetIrq) begin
			global_irq_enable_bit <= 1'b1; // RQ4
		end else if (ce && irqEntry) begin
			global_irq_enable_bit <= 1'b0;
		end
	end
	// the other bits belong to interrupt sources outside this block and read 0 here
	assign irqControlReg = {global_irq_enable_bit, 7'h00};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstSync_n);

	chk_load_literal: assert property (exec && isLoadLit |=> workReg == $past(literal)) // RQ1
		else $error("load literal did not reach work register");
	chk_nop_pc: assert property (exec && isNop |=> pcOut == $past(pcOut) + 13'h0001 && !busy) // RQ2
		else $error("no-operation did not just advance pc");
	chk_nop_work: assert property (exec && isNop |=> $stable(workReg)) // RQ2
		else $error("no-operation changed work register");
	chk_irq_ret_pc: assert property (exec && isRetIrq |=> pcOut == $past(topOfStack)) // RQ3
		else $error("irq return pc not from stack");
	chk_irq_ret_gie: assert property (exec && isRetIrq |=> irqControlReg[lrie_pkg::GIE_BIT]) // RQ4
		else $error("irq return left interrupts disabled");
	chk_ret_lit_work: assert property (exec && isRetLit |=> workReg == $past(literal)) // RQ5
		else $error("return literal did not load work register");
	chk_ret_two_cyc: assert property (exec && isRet |=> busy ##1 !busy && instrDone) // RQ6
		else $error("return did not take two cycles");
	chk_return_pc: assert property (exec && isReturn |=> pcOut == $past(topOfStack)
		&& $stable(workReg)) // RQ7
		else $error("return pc not from stack");
	chk_flush_hold: assert property (ce && busy |=> $stable(pcOut)) // RQ3
		else $error("pc moved in the idle return cycle");

	// ---------------------------------------------------------------
	// checks on cycle counts, the return-literal target and the idle return cycle
	// ---------------------------------------------------------------
	chk_load_one_cyc: assert property (exec && isLoadLit |=> // RQ1
		pcOut == $past(pcOut) + 13'h0001 && !busy && instrDone)
		else $error("load literal did not finish in one cycle");
	chk_irq_ret_cyc: assert property (exec && isRetIrq |=> busy ##1 !busy && instrDone) // RQ3
		else $error("irq return did not take two cycles");
	chk_return_cyc: assert property (exec && isReturn |=> busy ##1 !busy && instrDone) // RQ7
		else $error("return did not take two cycles");
	chk_ret_lit_pc: assert property (exec && isRetLit |=> pcOut == $past(topOfStack)) // RQ6
		else $error("return literal pc not from stack");
	chk_flush_refuse: assert property (ce && busy && !irqEntry |=> !busy // RQ3
		&& $stable(workReg) && $stable(irqControlReg))
		else $error("word executed in the idle return cycle");

	// ---------------------------------------------------------------
	// checks on registers left alone, and on interrupt entry clearing the enable
	// ---------------------------------------------------------------
	chk_nop_irq_keep: assert property (exec && isNop && !irqEntry |=> $stable(irqControlReg)) // RQ2
		else $error("no-operation changed irq control");
	chk_irq_ret_work: assert property (exec && isRetIrq |=> $stable(workReg)) // RQ3
		else $error("irq return changed work register");
	chk_entry_clear: assert property (ce && irqEntry && !(exec && isRetIrq) |=> // RQ4
		!irqControlReg[lrie_pkg::GIE_BIT])
		else $error("interrupt entry left interrupts enabled");
	chk_ret_lit_keep: assert property (exec && isRetLit && !irqEntry |=> // RQ5
		$stable(irqControlReg))
		else $error("return literal changed irq control");
	chk_return_keep: assert property (exec && isReturn && !irqEntry |=> // RQ7
		$stable(irqControlReg))
		else $error("return changed irq control");

	cov_load_lit: cover property (exec && isLoadLit);
	cov_ret_irq: cover property (exec && isRetIrq ##2 exec);
	cov_ret_lit: cover property (exec && isRetLit);
	cov_return: cover property (exec && isReturn);
	cov_idle_refused: cover property (busy && instrValid);
endmodule // lrie_exec

// [verif/lrie_prog_mem.sv]
// program memory model that feeds instruction words to the executor
`timescale 1ns/1ps
module lrie_prog_mem (
	// fetch address and word
	addr,
	word
);
	input wire logic [12:0] addr;
	output logic [13:0] word;
	logic [13:0] mem [0:8191];
	// ---------------------------------------------------------------
	// unloaded places read as no-operation
	// ---------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 14'h0000;
		end
	end
	// word follows the address with no delay, like a settled fetch
	assign word = mem[addr];
endmodule // lrie_prog_mem

// [verif/lrie_exec_tb_top.sv]
// testbench for the literal and return instruction executor
`timescale 1ns/1ps
module lrie_exec_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic instrValid = 1'b0;
	logic pushReq = 1'b0;
	logic [12:0] pushAddr = 13'h0000;
	logic irqEntry = 1'b0;
	logic [13:0] instrWord;
	logic [7:0] workReg;
	logic [12:0] pcOut;
	logic [7:0] irqControlReg;
	logic instrDone;
	logic busy;
	int failures = 0;
	int n_checks = 0;
	always #10 clk = ~clk;
	lrie_prog_mem u_mem (.addr(pcOut), .word(instrWord));
	lrie_exec u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .instrWord(instrWord),
		.instrValid(instrValid), .pushReq(pushReq), .pushAddr(pushAddr),
		.irqEntry(irqEntry), .workReg(workReg), .pcOut(pcOut),
		.irqControlReg(irqControlReg), .instrDone(instrDone), .busy(busy));
	// ---------------------------------------------------------------
	// compare and drive helpers
	// ---------------------------------------------------------------
	task automatic report(input string msg);
		failures++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask
	task automatic cmp_addr(input logic [12:0] got, input logic [12:0] exp);
		n_checks++;
		if (got !== exp) report($sformatf("addr %h exp %h", got, exp));
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) report($sformatf("byte %h exp %h", got, exp));
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) report($sformatf("bit %b exp %b", got, exp));
	endtask
	// inputs move 1 ns after the edge so the design samples settled values
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic exec_word();
		instrValid = 1'b1;
		tick();
		instrValid = 1'b0;
	endtask
	task automatic push(input logic [12:0] a);
		pushAddr = a;
		pushReq = 1'b1;
		tick();
		pushReq = 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_load();
		exec_word();
		cmp_byte(workReg, 8'h5A);
		cmp_addr(pcOut, 13'h0001);
		cmp_bit(instrDone, 1'b1);
		cmp_bit(busy, 1'b0);
		tick();
		cmp_bit(instrDone, 1'b0);
	endtask
	task automatic t_nop();
		exec_word();
		cmp_byte(workReg, 8'h5A);
		cmp_addr(pcOut, 13'h0002);
		cmp_byte(irqControlReg, 8'h00);
		cmp_bit(instrDone, 1'b1);
		tick();
	endtask
	task automatic t_return();
		push(13'h0100);
		// valid stays up through the idle cycle, where the word must be ignored
		instrValid = 1'b1;
		tick();
		cmp_addr(pcOut, 13'h0100);
		cmp_bit(busy, 1'b1);
		tick();
		instrValid = 1'b0;
		cmp_bit(instrDone, 1'b1);
		cmp_bit(busy, 1'b0);
		cmp_addr(pcOut, 13'h0100);
		cmp_byte(irqControlReg, 8'h00);
	endtask
	task automatic t_ret_irq();
		push(13'h0123);
		tick();
		push(13'h0200);
		irqEntry = 1'b1;
		tick();
		irqEntry = 1'b0;
		cmp_byte(irqControlReg, 8'h00);
		exec_word();
		cmp_addr(pcOut, 13'h0200);
		cmp_byte(irqControlReg, 8'h80);
		cmp_byte(workReg, 8'h5A);
		cmp_bit(busy, 1'b1);
		tick();
		cmp_bit(instrDone, 1'b1);
		// an interrupt entry clears the enable again
		irqEntry = 1'b1;
		tick();
		irqEntry = 1'b0;
		cmp_byte(irqControlReg, 8'h00);
	endtask
	task automatic t_ret_lit();
		push(13'h0300);
		exec_word();
		cmp_byte(workReg, 8'hA5);
		cmp_addr(pcOut, 13'h0300);
		cmp_bit(busy, 1'b1);
		tick();
		cmp_bit(instrDone, 1'b1);
		ce = 1'b0;
		exec_word();
		ce = 1'b1;
		cmp_addr(pcOut, 13'h0300);
		// a nop then a plain return: the return must find the older address
		tick();
		instrValid = 1'b1;
		repeat (2) tick();
		instrValid = 1'b0;
		cmp_addr(pcOut, 13'h0123);
		cmp_bit(busy, 1'b1);
		cmp_byte(workReg, 8'hA5);
	endtask
	initial begin
		// loaded after the model has cleared itself at time zero
		repeat (4) @(posedge clk);
		u_mem.mem[0] = {lrie_pkg::OPC_LOAD_LIT, 2'b00, 8'h5A};
		u_mem.mem[2] = lrie_pkg::OP_RETURN;
		u_mem.mem[13'h0100] = lrie_pkg::OP_RET_IRQ;
		u_mem.mem[13'h0200] = {lrie_pkg::OPC_RET_LIT, 2'b00, 8'hA5};
		u_mem.mem[13'h0301] = lrie_pkg::OP_RETURN;
		#1;
		rst_n = 1'b1;
		repeat (3) tick();
		t_load();
		t_nop();
		t_return();
		t_ret_irq();
		t_ret_lit();
		give_verdict();
	end
	// a hang counts as a mismatch
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule // lrie_exec_tb_top
